// ===== bench/irqvr_mem.sv
/* Stack and program memory model for the block's memory port.
   Assumes one request at a time, held until acknowledged. */
`default_nettype none
module irqvr_mem (
  // Clock
  input wire logic sys_clk,
  // Request
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic [3:0] dly,
  // Answer
  output logic [7:0] mem_rdata,
  output logic mem_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535];
  logic [15:0] log_q [$];
  logic [3:0] wait_ff = 4'h0;
  // Every byte holds its low address byte
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 8'h00;
    foreach (mem[i])
      mem[i] = i[7:0];
  end
  // Answer after dly cycles; data line toggles outside the ack
  always @(posedge sys_clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && mem_ack) begin
      log_q.push_back(mem_addr);
      if (mem_we)
        mem[mem_addr] = mem_wdata;
      wait_ff <= 4'h0;
    end else if (mem_req && wait_ff >= dly) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem[mem_addr];
    end else if (mem_req)
      wait_ff <= wait_ff + 4'h1;
  end
endmodule
`default_nettype wire

// ===== bench/irqvr_top_assertions.sv
/* Port checker for irqvr_top.
   Assumes it is bound to irqvr_top and sees only its ports. */
`default_nettype none
module irqvr_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Memory port and status
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic mem_ack,
  input wire logic busy,
  input wire logic [7:0] condition_code_reg
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] wr_cnt_ff;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  // Counts stack writes since the last read
  always_ff @(posedge sys_clk) begin
    if (!reset_n || (mem_req && mem_ack && !mem_we))
      wr_cnt_ff <= 3'h0;
    else if (mem_req && mem_ack)
      wr_cnt_ff <= wr_cnt_ff + 3'h1;
  end
  AST_RST_MASK: assert property (disable iff (1'b0) !reset_n |=> condition_code_reg == 8'h08)
    else $error("mask not set by reset");
  AST_HOLD: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request not held");
  AST_GAP: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("no gap after memory ack");
  AST_IDLE: assert property ($rose(mem_req) |-> busy)
    else $error("memory used while idle");
  AST_PUSH: assert property (mem_req && mem_we && mem_ack ##2 mem_req && mem_we |->
    mem_addr == $past(mem_addr, 2) - 16'h0001)
    else $error("stack pointer not decremented");
  AST_MASK: assert property (mem_req && mem_we && mem_ack ##2 mem_req && !mem_we |->
    ##[0:60] condition_code_reg[3])
    else $error("mask not set after stacking");
  AST_FIVE: assert property (wr_cnt_ff <= 3'h5)
    else $error("more than five bytes stacked");
  AST_RST_FETCH: assert property ($rose(reset_n) |-> ##[0:20] mem_req && mem_addr == 16'hFFBD)
    else $error("protect byte not read after reset");
  // Main scenarios
  COV_PUSH: cover property (mem_req && mem_we && mem_ack);
  COV_SLOW: cover property (mem_req && !mem_ack [*3]);
  COV_RET: cover property ($fell(busy) && !condition_code_reg[3]);
endmodule
bind irqvr_top irqvr_chk chk (.sys_clk, .reset_n, .mem_req, .mem_we, .mem_addr, .mem_ack, .busy,
  .condition_code_reg);
`default_nettype wire

// ===== bench/test_irq_entry_exit_vector_redirect.sv
/* Testbench for irqvr_top with a memory model.
   Assumes design, checker and model are compiled first. */
`default_nettype none
module test_irq_entry_exit_vector_redirect;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [30:0] irq_req = 31'h0;
  logic [3:0] dly = 4'h0;
  wire [31:0] prdata;
  wire pready, pslverr, mem_req, mem_we, mem_ack, busy;
  wire [15:0] mem_addr;
  wire [7:0] mem_wdata, mem_rdata, condition_code_reg;
  int error_cnt = 0;
  int tests_run = 0;
  logic [31:0] rd;
  logic err;
  irqvr_top dut (.sys_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq_req, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .busy,
    .condition_code_reg);
  irqvr_mem mm (.sys_clk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .dly, .mem_rdata, .mem_ack);
  // Compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Wait until the sequencer is done
  task automatic idle();
    repeat (3) @(posedge sys_clk);
    while (busy !== 1'b0)
      @(posedge sys_clk);
  endtask
  task automatic rst();
    reset_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    mm.log_q.delete();
    reset_n <= 1'b1;
    idle();
  endtask
  task automatic t_reset();
    rst();
    chk(32'(condition_code_reg), 32'h08);
    chk(32'(mm.log_q[1]), 32'hFFBF);
    chk(32'(mm.log_q[2]), 32'hFFFE);
    apb(1'b0, 12'h100, 32'h0);
    chk(32'(err), 32'h1);
    $display("reset test done");
  endtask
  task automatic t_mask();
    irq_req <= 31'h28;
    apb(1'b1, 12'h000, 32'h1);
    repeat (6) @(posedge sys_clk);
    chk(32'(busy), 32'h0);
    irq_req <= 31'h0;
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h28);
    $display("mask test done");
  endtask
  task automatic t_entry();
    apb(1'b1, 12'h014, 32'h80);
    apb(1'b1, 12'h020, 32'h1234);
    apb(1'b1, 12'h024, 32'h62A53C);
    mm.log_q.delete();
    apb(1'b1, 12'h000, 32'h1);
    idle();
    chk(32'(mm.mem[16'h80]), 32'h34);
    chk(32'(mm.mem[16'h7F]), 32'h12);
    chk(32'({mm.mem[16'h7D], mm.mem[16'h7E]}), 32'hA53C);
    chk(32'(mm.mem[16'h7C]), 32'h62);
    apb(1'b0, 12'h014, 32'h0);
    chk(rd, 32'h7B);
    chk(32'(condition_code_reg[3]), 32'h1);
    chk(32'(mm.log_q[5]), 32'hFFF4);
    chk(32'(mm.log_q[9]), 32'hF4F7);
    chk(32'(mm.log_q.size()), 32'hA);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'hF5F6F7);
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd, 32'h4);
    $display("entry test done");
  endtask
  task automatic t_rti();
    mm.log_q.delete();
    dly <= 4'h2;
    apb(1'b1, 12'h000, 32'h5);
    idle();
    chk(32'(condition_code_reg), 32'h62);
    chk(32'(mm.log_q[0]), 32'h7C);
    apb(1'b0, 12'h024, 32'h0);
    chk(rd, 32'h62A53C);
    repeat (6) @(posedge sys_clk);
    chk(32'(busy), 32'h0);
    mm.log_q.delete();
    apb(1'b1, 12'h000, 32'h1);
    idle();
    chk(32'(mm.log_q[5]), 32'hFFF0);
    mm.log_q.delete();
    apb(1'b1, 12'h000, 32'h3);
    idle();
    chk(32'(mm.log_q[5]), 32'hFFFC);
    $display("return test done");
  endtask
  task automatic t_redir();
    logic [7:0] pr [3] = '{8'hFC, 8'hFC, 8'h00};
    logic [7:0] op [3] = '{8'hBF, 8'hFF, 8'hBF};
    logic [15:0] va [3] = '{16'hFDFC, 16'hFFFC, 16'hFFFC};
    dly <= 4'h3;
    for (int i = 0; i < 3; i++) begin
      mm.mem[16'hFFBD] = pr[i];
      mm.mem[16'hFFBF] = op[i];
      rst();
      chk(32'(mm.log_q[2]), 32'hFFFE);
      apb(1'b0, 12'h004, 32'h0);
      chk(32'(rd[7]), 32'(i == 0));
      mm.log_q.delete();
      apb(1'b1, 12'h000, 32'h3);
      idle();
      chk(32'(mm.log_q[5]), 32'(va[i]));
    end
    $display("redirect test done");
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    t_reset();
    t_mask();
    t_entry();
    t_rti();
    t_redir();
    stop_test();
  end
  // Watchdog
  initial begin
    #1000000;
    error_cnt++;
    stop_test();
  end
endmodule
`default_nettype wire

// ===== design/irqvr_prio.v
/*
 Priority encoder over the pending interrupt sources.
 Assumes source 0 is the highest priority; purely combinational.
*/
`default_nettype none
module irqvr_prio (
  // Requests
  input wire [30:0] pend,
  // Result
  output reg any,
  output reg [4:0] idx
);
  integer i;
  // Lowest numbered pending source wins
  always @* begin
    any = 1'b0;
    idx = 5'h00;
    for (i = 30; i >= 0; i = i - 1) begin
      if (pend[i]) begin
        any = 1'b1;
        idx = i[4:0];
      end
    end
  end
endmodule
`default_nettype wire

// ===== design/irqvr_regs.vh
/*
 Constants for the interrupt entry, return and vector redirect block.
 Assumes inclusion by bare name from design files only.
*/
`ifndef IRQVR_REGS_VH
`define IRQVR_REGS_VH
// APB byte addresses of the block's own registers
`define IRQVR_OFF_CTRL 12'h000
`define IRQVR_OFF_STAT 12'h004
`define IRQVR_OFF_PEND 12'h008
`define IRQVR_OFF_CUR 12'h00C
`define IRQVR_OFF_VEC 12'h010
`define IRQVR_OFF_SP 12'h014
`define IRQVR_OFF_PROT 12'h018
`define IRQVR_OFF_OPT 12'h01C
`define IRQVR_OFF_NEXTPC 12'h020
`define IRQVR_OFF_CPU 12'h024
// Nonvolatile byte locations
`define IRQVR_ADDR_PROT 16'hFFBD
`define IRQVR_ADDR_OPT 16'hFFBF
// Vector table
`define IRQVR_VEC_BASE 16'hFFC0
`define IRQVR_VEC_IRQ_END 16'hFFFD
`define IRQVR_VEC_RESET 16'hFFFE
// Field positions
`define IRQVR_CCR_I_BIT 3
`define IRQVR_OPT_NORED_BIT 6
`define IRQVR_CTRL_INSTR_BIT 0
`define IRQVR_CTRL_SWI_BIT 1
`define IRQVR_CTRL_RTI_BIT 2
`define IRQVR_CTRL_CLI_BIT 3
// Reset values
`define IRQVR_RST_CCR 8'h08
`define IRQVR_RST_SP 16'h00FF
`define IRQVR_RST_PROT 8'hFF
`define IRQVR_RST_OPT 8'hFF
// Prefill byte count
`define IRQVR_PREFILL 2'h3
`endif

// ===== design/irqvr_top.v
/*
 Interrupt entry, return and vector redirect unit of an 8-bit CPU.
 Assumes APB3 register access, one stack/program memory port that answers
 each request with mem_ack, and level interrupt requests held until serviced.
*/
// Function
// - Reset sets the global interrupt mask in the condition code register.
// - A qualified request waits for the current instruction to finish.
// - Hardware entry uses the same sequence as the software interrupt instruction.
// - After stacking, the mask bit is set against nesting.
// - Fetch highest-priority vector, then prefill three program bytes from it.
// - Several pending at mask clear: highest priority serviced first.
// - Stack pointer addresses next free byte; write, then decrement.
// - Push program counter low byte first, condition code register last.
// - After stacking, pointer is one below the condition code location.
// - Stacked program counter is the next instruction address.
// - Return restores condition code, accumulator, low index and counter.
// - High index byte is never stacked or restored by hardware.
// - Any block protection makes the vector locations protected.
// - Redirection enabled when the redirect-disable option bit is zero.
// - Redirection only when some but not all flash is protected.
// - Interrupt vectors are redirected; the reset vector never is.
`default_nettype none
`include "irqvr_regs.vh"
module irqvr_top (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Interrupt requests
  input wire [30:0] irq_req,
  // Memory port
  output reg mem_req,
  output reg mem_we,
  output reg [15:0] mem_addr,
  output reg [7:0] mem_wdata,
  input wire [7:0] mem_rdata,
  input wire mem_ack,
  // Status
  output reg busy,
  output reg [7:0] condition_code_reg
);
  // States
  localparam ST_IDLE = 4'h0;
  localparam ST_PUSH = 4'h1;
  localparam ST_VECH = 4'h2;
  localparam ST_VECL = 4'h3;
  localparam ST_FILL = 4'h4;
  localparam ST_PULL = 4'h5;
  localparam ST_LOADP = 4'h6;
  localparam ST_LOADO = 4'h7;

  reg [3:0] state_ff;
  reg [2:0] step_ff;
  reg [1:0] fill_ff;
  reg [15:0] sp_ff;
  reg [15:0] pc_ff;
  reg [15:0] next_pc_ff;
  reg [7:0] acc_ff;
  reg [7:0] xlo_ff;
  reg [7:0] prot_ff;
  reg [7:0] opt_ff;
  reg [30:0] pend_ff;
  reg [4:0] cur_ff;
  reg cur_reset_ff;
  reg instr_done_ff;
  reg swi_ff;
  reg rti_ff;
  reg [23:0] queue_ff;
  reg [15:0] vec_addr_ff;
  reg entry_done_ff;
  reg [7:0] nxt_push;
  wire prio_any;
  wire [4:0] prio_idx;
  wire redir;
  wire [15:0] vec_addr;
  wire apb_wr;

  // Decode one APB address against a register offset
  function hit;
    input [11:0] a;
    input [11:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  irqvr_prio u_prio (
    .pend(pend_ff),
    .any(prio_any),
    .idx(prio_idx)
  );

  irqvr_vecaddr u_vec (
    .idx(cur_ff),
    .is_reset(cur_reset_ff),
    .prot(prot_ff),
    .opt(opt_ff),
    .redir(redir),
    .addr(vec_addr)
  );

  assign apb_wr = psel & penable & pwrite & pready;

  // Byte pushed in each stacking step
  always @* begin
    case (step_ff)
      3'h0: nxt_push = pc_ff[7:0];
      3'h1: nxt_push = pc_ff[15:8];
      3'h2: nxt_push = xlo_ff;
      3'h3: nxt_push = acc_ff;
      default: nxt_push = condition_code_reg;
    endcase
  end

  // APB: one wait state, answers in the second access cycle
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= 1'b0;
      if (psel & penable & ~pready) begin
        prdata <= 32'h00000000;
        if (hit(paddr, `IRQVR_OFF_STAT)) begin
          prdata <= {24'h000000, redir, entry_done_ff, busy, state_ff, condition_code_reg[`IRQVR_CCR_I_BIT]};
        end else if (hit(paddr, `IRQVR_OFF_PEND)) begin
          prdata <= {1'b0, pend_ff};
        end else if (hit(paddr, `IRQVR_OFF_CUR)) begin
          prdata <= {27'h0000000, cur_ff};
        end else if (hit(paddr, `IRQVR_OFF_VEC)) begin
          prdata <= {8'h00, queue_ff};
        end else if (hit(paddr, `IRQVR_OFF_SP)) begin
          prdata <= {16'h0000, sp_ff};
        end else if (hit(paddr, `IRQVR_OFF_PROT)) begin
          prdata <= {24'h000000, prot_ff};
        end else if (hit(paddr, `IRQVR_OFF_OPT)) begin
          prdata <= {24'h000000, opt_ff};
        end else if (hit(paddr, `IRQVR_OFF_NEXTPC)) begin
          prdata <= {16'h0000, pc_ff};
        end else if (hit(paddr, `IRQVR_OFF_CPU)) begin
          prdata <= {8'h00, condition_code_reg, acc_ff, xlo_ff};
        end else if (!hit(paddr, `IRQVR_OFF_CTRL)) begin
          pslverr <= 1'b1; // Unmapped address
        end
      end
    end
  end

  // Main sequencer
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      state_ff <= ST_LOADP;
      step_ff <= 3'h0;
      fill_ff <= 2'h0;
      sp_ff <= `IRQVR_RST_SP;
      pc_ff <= 16'h0000;
      next_pc_ff <= 16'h0000;
      acc_ff <= 8'h00;
      xlo_ff <= 8'h00;
      prot_ff <= `IRQVR_RST_PROT;
      opt_ff <= `IRQVR_RST_OPT;
      pend_ff <= 31'h00000000;
      cur_ff <= 5'h00;
      cur_reset_ff <= 1'b0;
      instr_done_ff <= 1'b0;
      swi_ff <= 1'b0;
      rti_ff <= 1'b0;
      queue_ff <= 24'h000000;
      vec_addr_ff <= 16'h0000;
      entry_done_ff <= 1'b0;
      condition_code_reg <= `IRQVR_RST_CCR;
      busy <= 1'b1;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 8'h00;
    end else begin
      // Requests latch and stay until their entry starts
      pend_ff <= pend_ff | irq_req;
      entry_done_ff <= 1'b0;
      // Software control strobes and CPU state writes
      if (apb_wr && hit(paddr, `IRQVR_OFF_CTRL)) begin
        if (pwdata[`IRQVR_CTRL_INSTR_BIT]) instr_done_ff <= 1'b1;
        if (pwdata[`IRQVR_CTRL_SWI_BIT]) swi_ff <= 1'b1;
        if (pwdata[`IRQVR_CTRL_RTI_BIT]) rti_ff <= 1'b1;
        if (pwdata[`IRQVR_CTRL_CLI_BIT]) condition_code_reg[`IRQVR_CCR_I_BIT] <= 1'b0;
      end
      if (apb_wr && hit(paddr, `IRQVR_OFF_SP)) sp_ff <= pwdata[15:0];
      if (apb_wr && hit(paddr, `IRQVR_OFF_NEXTPC)) next_pc_ff <= pwdata[15:0];
      if (apb_wr && hit(paddr, `IRQVR_OFF_CPU)) begin
        condition_code_reg <= pwdata[23:16];
        acc_ff <= pwdata[15:8];
        xlo_ff <= pwdata[7:0];
      end
      case (state_ff)
        // Copy nonvolatile bytes after reset, then fetch reset vector
        ST_LOADP: begin
          mem_req <= 1'b1;
          mem_addr <= `IRQVR_ADDR_PROT;
          if (mem_req && mem_ack) begin
            prot_ff <= mem_rdata;
            mem_req <= 1'b0;
            state_ff <= ST_LOADO;
          end
        end
        ST_LOADO: begin
          mem_req <= 1'b1;
          mem_addr <= `IRQVR_ADDR_OPT;
          if (mem_req && mem_ack) begin
            opt_ff <= mem_rdata;
            mem_req <= 1'b0;
            cur_reset_ff <= 1'b1;
            state_ff <= ST_VECH;
          end
        end
        ST_IDLE: begin
          busy <= 1'b0;
          // Wait for instruction boundary before any response
          if (instr_done_ff) begin
            instr_done_ff <= 1'b0;
            pc_ff <= next_pc_ff;
            if (rti_ff) begin
              rti_ff <= 1'b0;
              busy <= 1'b1;
              step_ff <= 3'h0;
              state_ff <= ST_PULL;
            end else if (swi_ff || (prio_any && !condition_code_reg[`IRQVR_CCR_I_BIT])) begin
              // Software instruction is unmaskable and uses vector slot 0
              busy <= 1'b1;
              cur_reset_ff <= 1'b0;
              if (!swi_ff) begin
                cur_ff <= prio_idx + 5'h01;
                pend_ff[prio_idx] <= irq_req[prio_idx]; // A request in this same cycle stays pending
              end else begin
                cur_ff <= 5'h00;
                swi_ff <= 1'b0;
              end
              step_ff <= 3'h0;
              state_ff <= ST_PUSH;
            end
          end
        end
        // Stack five bytes, write then decrement
        ST_PUSH: begin
          mem_req <= 1'b1;
          mem_we <= 1'b1;
          mem_addr <= sp_ff;
          mem_wdata <= nxt_push;
          if (mem_req && mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            sp_ff <= sp_ff - 16'h0001;
            if (step_ff == 3'h4) begin
              condition_code_reg[`IRQVR_CCR_I_BIT] <= 1'b1;
              state_ff <= ST_VECH;
            end else begin
              step_ff <= step_ff + 3'h1;
            end
          end
        end
        // Vector high then low byte
        ST_VECH: begin
          mem_req <= 1'b1;
          mem_addr <= vec_addr;
          if (mem_req && mem_ack) begin
            mem_req <= 1'b0;
            vec_addr_ff[15:8] <= mem_rdata;
            state_ff <= ST_VECL;
          end
        end
        ST_VECL: begin
          mem_req <= 1'b1;
          mem_addr <= vec_addr + 16'h0001;
          if (mem_req && mem_ack) begin
            mem_req <= 1'b0;
            vec_addr_ff[7:0] <= mem_rdata;
            fill_ff <= 2'h0;
            state_ff <= ST_FILL;
          end
        end
        // Prefill the instruction queue with three bytes
        ST_FILL: begin
          mem_req <= 1'b1;
          mem_addr <= vec_addr_ff + {14'h0000, fill_ff};
          if (mem_req && mem_ack) begin
            mem_req <= 1'b0;
            queue_ff <= {queue_ff[15:0], mem_rdata};
            if (fill_ff == `IRQVR_PREFILL - 2'h1) begin
              pc_ff <= vec_addr_ff + {14'h0000, `IRQVR_PREFILL};
              entry_done_ff <= 1'b1;
              state_ff <= ST_IDLE;
            end else begin
              fill_ff <= fill_ff + 2'h1;
            end
          end
        end
        // Unstack in reverse order: CONDITION_CODE_REG, A, X, PC high, PC low
        ST_PULL: begin
          mem_req <= 1'b1;
          mem_addr <= sp_ff + 16'h0001;
          if (mem_req && mem_ack) begin
            mem_req <= 1'b0;
            sp_ff <= sp_ff + 16'h0001;
            case (step_ff)
              3'h0: condition_code_reg <= mem_rdata;
              3'h1: acc_ff <= mem_rdata;
              3'h2: xlo_ff <= mem_rdata;
              3'h3: pc_ff[15:8] <= mem_rdata;
              default: pc_ff[7:0] <= mem_rdata;
            endcase
            if (step_ff == 3'h4) begin
              state_ff <= ST_IDLE;
            end else begin
              step_ff <= step_ff + 3'h1;
            end
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== design/irqvr_vecaddr.v
/*
 Vector address generator with redirection.
 Assumes protect byte bits 7:1 name the last unprotected 512-byte page; protection starts one page higher.
*/
`default_nettype none
`include "irqvr_regs.vh"
module irqvr_vecaddr (
  // Source and nonvolatile bytes
  input wire [4:0] idx,
  input wire is_reset,
  input wire [7:0] prot,
  input wire [7:0] opt,
  // Result
  output wire redir,
  output wire [15:0] addr
);
  wire prot_on;
  wire prot_all;
  wire [15:0] def_addr;
  wire [15:0] prot_start;
  // Protection active when enable bit (bit 0) is zero
  assign prot_on = ~prot[0];
  assign prot_all = prot_on & (prot[7:1] == 7'h00);
  assign redir = ~opt[`IRQVR_OPT_NORED_BIT] & prot_on & ~prot_all;
  assign def_addr = `IRQVR_VEC_IRQ_END - 16'h0001 - {10'h000, idx, 1'b0};
  assign prot_start = {prot[7:1], 9'h000} + 16'h0200;
  // Same offset within the table, just below the protected region
  assign addr = is_reset ? `IRQVR_VEC_RESET :
    (redir ? (prot_start - 16'h0040 + {10'h000, def_addr[5:0]}) : def_addr);
endmodule
`default_nettype wire
